/* File: core/reset_state_initializer.sv */
// reset-state register bank with wake-up vectoring and stack push
// assumes reset sources, wake events and writes are pulses on i_clk
`timescale 1ns/1ns
`include "reset_state_consts.svh"
module reset_state_initializer
  import reset_state_pkg::*;
#(
  parameter int STACK_DEPTH = `RSI_STACK_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_bor,
  input wire logic i_other_rst,
  input wire logic i_sleep,
  input wire logic i_wake_wdt,
  input wire logic i_wake_irq,
  input wire logic i_wake_irq_high,
  input wire logic [7:0] i_wake_irq_flags,
  input wire logic i_high_prio_global_irq_enable,
  input wire logic i_low_prio_global_irq_enable,
  input wire logic [20:0] i_pc,
  input wire osc_mode_t i_osc_mode,
  input wire logic i_ra6_present,
  input wire logic [7:0] i_port_a_pins,
  input wire wr_req_t i_wr,
  output regs_t o_regs,
  output logic o_asleep,
  output logic o_pc_load,
  output logic [20:0] o_pc_vector,
  output stack_top_t o_stack_top,
  output logic [4:0] o_return_stack_pointer
);
  localparam logic [`RSI_NREG*8-1:0] POR_VALS = `RSI_POR_VALS;
  localparam logic [`RSI_NREG*8-1:0] IMPL_MASKS = `RSI_IMPL_MASKS;
  localparam logic [`RSI_NREG*8-1:0] KEEP_MASKS = `RSI_KEEP_MASKS;

  logic por;
  logic any_rst;
  logic ra6_live;
  logic [7:0] ra6_mask;
  logic [`RSI_NREG*8-1:0] bank;
  wake_state_t state_r;
  wake_state_t state_nxt;
  logic wake_irq_r;
  logic wake_high_r;
  logic vector_ok;
  logic [7:0] ictl_r;
  logic [7:0] ictl_nxt;
  logic [7:0] pflag_r;
  logic [7:0] pflag_nxt;
  logic pc_load_r;
  logic [20:0] pc_vector_r;
  logic [4:0] sp_r;
  logic [4:0] sp_nxt;
  logic [20:0] push_pc_r;
  logic [20:0] stack_mem [1:STACK_DEPTH];
  logic [20:0] tos_r;

  assign por = i_rst | i_por_bor;
  assign any_rst = por | i_other_rst;
  assign ra6_live = i_ra6_present &&
    (i_osc_mode == OSC_EXT_CLK_IO || i_osc_mode == OSC_RC_IO); // RULE4
  assign ra6_mask = ra6_live ? 8'hFF : ~(8'h01 << `RSI_RA6_BIT); // RULE5

  // register bank, one keeper per register
  genvar g;
  generate
    for (g = 0; g < `RSI_NREG; g = g + 1) begin : g_bank
      reg_keeper #(
        .POR_VAL(POR_VALS[g*8 +: 8]),
        .IMPL(IMPL_MASKS[g*8 +: 8]),
        .KEEP(KEEP_MASKS[g*8 +: 8])
      ) u_reg (
        .i_clk(i_clk),
        .i_por(por),
        .i_other_rst(i_other_rst),
        .i_wr(i_wr.en && i_wr.sel == reg_sel_t'(g)),
        .i_data(i_wr.data),
        .o_q(bank[g*8 +: 8])
      );
    end
  endgenerate

  // bank contents seen by software
  always_comb begin
    o_regs = '0;
    o_regs.conv0 = bank[0 +: 8]; // RULE6
    o_regs.tx = bank[8 +: 8]; // RULE7
    o_regs.rx = bank[16 +: 8]; // RULE8
    o_regs.timer3 = bank[24 +: 8]; // RULE9
    o_regs.eeprom1 = bank[32 +: 8]; // RULE10
    o_regs.port_e_dir = bank[40 +: 8]; // RULE11
    o_regs.prio2 = bank[48 +: 8]; // RULE12
    o_regs.port_a_dir = bank[56 +: 8] & ra6_mask; // RULE4
    o_regs.port_a_latch = bank[64 +: 8] & ra6_mask; // RULE4
    o_regs.port_a_pins = i_port_a_pins & 8'h7F & ra6_mask; // RULE5
    o_regs.ictl = ictl_r;
    o_regs.pflag = pflag_r;
  end

  // sleep and wake sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (i_sleep) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (i_wake_irq && vector_ok) begin
          state_nxt = ST_VECTOR;
        end else if (i_wake_irq || i_wake_wdt) begin
          state_nxt = ST_RUN;
        end
      end
      ST_VECTOR: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  assign vector_ok = i_wake_irq_high ? i_high_prio_global_irq_enable
                                     : i_low_prio_global_irq_enable;

  always_ff @(posedge i_clk) begin
    if (any_rst) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (any_rst) begin
      wake_irq_r <= 1'b0;
      wake_high_r <= 1'b0;
      push_pc_r <= '0;
    end else if (state_r == ST_SLEEP && i_wake_irq) begin
      wake_irq_r <= 1'b1;
      wake_high_r <= i_wake_irq_high;
      push_pc_r <= i_pc;
    end else begin
      wake_irq_r <= 1'b0;
    end
  end
  assign o_asleep = (state_r == ST_SLEEP);

  // wake cause flags, hardware set wins over software write
  always_comb begin
    ictl_nxt = ictl_r;
    pflag_nxt = pflag_r;
    if (i_wr.en && i_wr.sel == SEL_ICTL) begin
      ictl_nxt = i_wr.data;
    end
    if (i_wr.en && i_wr.sel == SEL_PFLAG) begin
      pflag_nxt = i_wr.data;
    end
    if (state_r == ST_SLEEP && i_wake_wdt) begin
      ictl_nxt[`RSI_ICTL_WDT_BIT] = 1'b1; // RULE1
    end
    if (state_r == ST_SLEEP && i_wake_irq) begin
      pflag_nxt = pflag_nxt | i_wake_irq_flags; // RULE1
    end
  end

  always_ff @(posedge i_clk) begin
    if (any_rst) begin
      ictl_r <= `RSI_FLAG_RESET;
      pflag_r <= `RSI_FLAG_RESET;
    end else begin
      ictl_r <= ictl_nxt;
      pflag_r <= pflag_nxt;
    end
  end

  // vector load
  always_ff @(posedge i_clk) begin
    if (any_rst) begin
      pc_load_r <= 1'b0;
      pc_vector_r <= '0;
    end else if (state_r == ST_VECTOR) begin
      pc_load_r <= 1'b1; // RULE2
      pc_vector_r <= wake_high_r ? `RSI_VEC_HIGH : `RSI_VEC_LOW; // RULE2
    end else begin
      pc_load_r <= 1'b0;
    end
  end
  assign o_pc_load = pc_load_r;
  assign o_pc_vector = pc_vector_r;

  // return stack push
  always_comb begin
    sp_nxt = sp_r;
    if (state_r == ST_VECTOR && sp_r < 5'(STACK_DEPTH)) begin
      sp_nxt = sp_r + 5'h01; // RULE3
    end
  end

  always_ff @(posedge i_clk) begin
    if (any_rst) begin
      sp_r <= '0;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (state_r == ST_VECTOR && !any_rst && sp_nxt != sp_r) begin
      stack_mem[sp_nxt] <= push_pc_r; // RULE3
    end
  end

  always_ff @(posedge i_clk) begin
    if (any_rst) begin
      tos_r <= '0;
    end else if (state_r == ST_VECTOR && sp_nxt != sp_r) begin
      tos_r <= push_pc_r; // RULE3
    end
  end
  assign o_stack_top = stack_top_t'({3'h0, tos_r});
  assign o_return_stack_pointer = sp_r;

  // checks
  sequence s_irq_wake;
    state_r == ST_SLEEP && i_wake_irq && vector_ok && !any_rst;
  endsequence
  sequence s_wdt_wake;
    state_r == ST_SLEEP && i_wake_wdt && !any_rst;
  endsequence

  a_wdt_flag: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
    s_wdt_wake |=> ictl_r[`RSI_ICTL_WDT_BIT])
    else $error("watchdog wake left no cause flag");
  a_irq_flag: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
    state_r == ST_SLEEP && i_wake_irq && !any_rst && i_wake_irq_flags != 8'h00
    |=> pflag_r != 8'h00)
    else $error("interrupt wake left no cause flag");
  a_vector_load: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
    s_irq_wake ##1 !any_rst |=> !any_rst |-> o_pc_load
      && o_pc_vector == ($past(i_wake_irq_high, 2) ? `RSI_VEC_HIGH : `RSI_VEC_LOW))
    else $error("vector not loaded after wake");
  a_no_vector_off: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
    state_r == ST_SLEEP && i_wake_irq && !vector_ok && !any_rst ##1 !any_rst
    |=> !o_pc_load)
    else $error("vector loaded with global enable clear");
  a_vector_cause: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
    state_r == ST_VECTOR |-> wake_irq_r)
    else $error("vector state without interrupt wake");
  a_pc_load_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
    o_pc_load |=> !o_pc_load)
    else $error("vector load longer than one cycle");
  a_stack_push: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
    s_irq_wake ##1 !any_rst |=> (($past(sp_r) < 5'(STACK_DEPTH))
      ? (o_stack_top == stack_top_t'({3'h0, $past(i_pc, 2)})
         && o_return_stack_pointer == $past(sp_r) + 5'h01)
      : ($stable(o_stack_top) && $stable(o_return_stack_pointer))))
    else $error("stack not pushed on wake");
  a_stack_entry: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
    state_r == ST_VECTOR && sp_r < 5'(STACK_DEPTH) && !any_rst
    |=> stack_mem[sp_r] == tos_r)
    else $error("stack entry differs from top of stack");
  a_ra6_masked: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
    !(i_osc_mode == OSC_EXT_CLK_IO || i_osc_mode == OSC_RC_IO)
    |-> !o_regs.port_a_dir[6] && !o_regs.port_a_latch[6] && !o_regs.port_a_pins[6])
    else $error("port a bit 6 live in wrong mode");
  a_ra6_absent: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
    !i_ra6_present |-> !o_regs.port_a_dir[6] && !o_regs.port_a_pins[6])
    else $error("absent port a bit 6 reads one");
  a_conv0_reset: assert property (@(posedge i_clk) // RULE6
    any_rst |=> o_regs.conv0 == 8'h00)
    else $error("converter control 0 reset wrong");
  a_conv0_wake: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
    state_r == ST_SLEEP && i_wake_wdt && !any_rst && !i_wr.en
    |=> $stable(o_regs.conv0))
    else $error("converter control 0 changed across wake");
  a_tx_reset: assert property (@(posedge i_clk) // RULE7
    any_rst |=> o_regs.tx == 8'h02)
    else $error("transmit status reset wrong");
  a_tx_wake: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
    state_r == ST_SLEEP && i_wake_irq && !any_rst && !i_wr.en
    |=> $stable(o_regs.tx))
    else $error("transmit status changed across wake");
  a_rx_reset: assert property (@(posedge i_clk) // RULE8
    any_rst |=> o_regs.rx[7:1] == 7'h00)
    else $error("receive status reset wrong");
  a_timer3_keep: assert property (@(posedge i_clk) // RULE9
    !por && i_other_rst |=> $stable(o_regs.timer3))
    else $error("timer 3 control lost on other reset");
  a_eeprom_reset: assert property (@(posedge i_clk) // RULE10
    any_rst |=> (o_regs.eeprom1 & 8'h37) == 8'h00)
    else $error("eeprom control 1 defined bits not cleared");
  a_port_e_reset: assert property (@(posedge i_clk) // RULE11
    any_rst |=> o_regs.port_e_dir == 8'h07)
    else $error("port e direction reset wrong");
  a_prio2_wake: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
    s_wdt_wake ##1 !any_rst && !(i_wr.en && i_wr.sel == SEL_PRIO2)
    |=> $stable(o_regs.prio2))
    else $error("priority 2 changed across wake");
  a_prio2_reset: assert property (@(posedge i_clk) // RULE12
    any_rst |=> o_regs.prio2 == 8'h1F)
    else $error("priority 2 reset wrong");
  a_rx_undef_bit: assert property (@(posedge i_clk) // RULE13
    !por && i_other_rst |=> o_regs.rx[0] == $past(o_regs.rx[0]))
    else $error("undefined receive bit forced on other reset");
endmodule

/* File: core/reset_state_consts.svh */
// reset and wake-up initial values for the peripheral and port register bank
// assumes a single core clock and reset-source pulses synchronous to it
// Functional notes
// RULE1: a wake from sleep by watchdog or interrupt sets a cause flag bit.
// RULE2: interrupt wake with a global enable set loads the matching vector.
// RULE3: that wake copies the program counter to top of stack and bumps pointer; the code skips both once the pointer is at 31.
// RULE4: port A bit 6 is live only in external-clock or RC modes with I/O.
// RULE5: port A bit 6 reads zero on variants that lack it.
// RULE6: converter control 0 resets to 0000 00-0 and holds across wake.
// RULE7: serial transmit status resets to 0000 -010 and holds across wake.
// RULE8: serial receive status resets to 0000 000x and holds across wake.
// RULE9: timer 3 control clears only on power-on or brown-out reset.
// RULE10: eeprom control 1 powers up xx-0 x000, later resets keep the x bits.
// RULE11: port E direction resets to 0000 -111 and holds across wake.
// RULE12: interrupt priority 2 resets to 1 1111 and holds across wake.
// RULE13: undefined reset bits are never relied on before software writes them.
`ifndef RESET_STATE_CONSTS_SVH
`define RESET_STATE_CONSTS_SVH
`define RSI_W 8
`define RSI_NREG 9
// index order 8..0: port_a_latch, port_a_dir, prio2, port_e_dir, eeprom1,
// timer3, rx, tx, conv0
`define RSI_POR_VALS {8'h00, 8'h7F, 8'h1F, 8'h07, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00}
`define RSI_IMPL_MASKS {8'h7F, 8'h7F, 8'h1F, 8'hF7, 8'hDF, 8'hFF, 8'hFF, 8'hF7, 8'hFD}
`define RSI_KEEP_MASKS {8'h7F, 8'h00, 8'h00, 8'h00, 8'hC8, 8'hFF, 8'h01, 8'h00, 8'h00}
`define RSI_PC_W 21
`define RSI_VEC_HIGH 21'h000008
`define RSI_VEC_LOW 21'h000018
`define RSI_SP_W 5
`define RSI_STACK_DEPTH 31
`define RSI_RA6_BIT 3'h6
`define RSI_ICTL_WDT_BIT 3'h2
`define RSI_FLAG_RESET 8'h00
`endif

/* File: core/reset_state_pkg.sv */
// types shared by the reset-state register bank
// assumes the constants header is included by the user
package reset_state_pkg;
  typedef enum logic [3:0] {
    SEL_CONV0 = 4'h0,
    SEL_TX = 4'h1,
    SEL_RX = 4'h2,
    SEL_TIMER3 = 4'h3,
    SEL_EEPROM1 = 4'h4,
    SEL_PORT_E_DIR = 4'h5,
    SEL_PRIO2 = 4'h6,
    SEL_PORT_A_DIR = 4'h7,
    SEL_PORT_A_LATCH = 4'h8,
    SEL_ICTL = 4'h9,
    SEL_PFLAG = 4'hA
  } reg_sel_t;
  typedef enum logic [2:0] {
    OSC_LP = 3'h0,
    OSC_XT = 3'h1,
    OSC_HS = 3'h2,
    OSC_HS_PLL = 3'h3,
    OSC_RC = 3'h4,
    OSC_EXT_CLK = 3'h5,
    OSC_EXT_CLK_IO = 3'h6,
    OSC_RC_IO = 3'h7
  } osc_mode_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_VECTOR = 2'b10
  } wake_state_t;
  typedef struct packed {
    logic en;
    reg_sel_t sel;
    logic [7:0] data;
  } wr_req_t;
  typedef struct packed {
    logic [7:0] conv0;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] timer3;
    logic [7:0] eeprom1;
    logic [7:0] port_e_dir;
    logic [7:0] prio2;
    logic [7:0] port_a_dir;
    logic [7:0] port_a_latch;
    logic [7:0] port_a_pins;
    logic [7:0] ictl;
    logic [7:0] pflag;
  } regs_t;
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] high;
    logic [7:0] low;
  } stack_top_t;
endpackage

/* File: core/reg_keeper.sv */
// one register with power-on, other-reset and software-write behaviour
// assumes reset pulses are synchronous and wake-up needs no action here
`timescale 1ns/1ns
`include "reset_state_consts.svh"
module reg_keeper #(
  parameter logic [7:0] POR_VAL = 8'h00,
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] KEEP = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_por,
  input wire logic i_other_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_q
);
  logic [7:0] q_r;
  // unimplemented bits are held at zero in every case
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      q_r <= POR_VAL & IMPL;
    end else if (i_other_rst) begin
      q_r <= ((q_r & KEEP) | (POR_VAL & ~KEEP)) & IMPL;
    end else if (i_wr) begin
      q_r <= i_data & IMPL;
    end
  end
  assign o_q = q_r;

  a_por_value: assert property (@(posedge i_clk)
    i_por |=> o_q == (POR_VAL & IMPL))
    else $error("register not at power-on value");
  a_other_keep: assert property (@(posedge i_clk) // RULE13
    !i_por && i_other_rst |=> o_q == ((($past(o_q) & KEEP) | (POR_VAL & ~KEEP)) & IMPL))
    else $error("other reset gave wrong value");
  a_hold_idle: assert property (@(posedge i_clk)
    !i_por && !i_other_rst && !i_wr |=> $stable(o_q))
    else $error("register changed without cause");
endmodule

/* File: verif/reset_state_initializer_tb_top.sv */
// self-checking bench for the reset-state register bank
// assumes reset_state_pkg is compiled first and i_clk runs at 10 MHz
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %0h exp %0h", $time, (g), (e)); end end
module reset_state_initializer_tb_top;
  import reset_state_pkg::*;
  typedef struct packed {
    reg_sel_t sel;
    logic [7:0] wr;
    logic [7:0] por;
    logic [7:0] oth;
  } row_t;
  // sel, data written, after power-on, after other reset
  row_t rows [9] = '{
    '{SEL_CONV0, 8'hFF, 8'h00, 8'h00}, '{SEL_TX, 8'hFF, 8'h02, 8'h02},
    '{SEL_RX, 8'hFF, 8'h00, 8'h01}, '{SEL_TIMER3, 8'hFF, 8'h00, 8'hFF},
    '{SEL_EEPROM1, 8'hFF, 8'h00, 8'hC8}, '{SEL_PORT_E_DIR, 8'hFF, 8'h07, 8'h07},
    '{SEL_PRIO2, 8'hFF, 8'h1F, 8'h1F}, '{SEL_PORT_A_DIR, 8'hFF, 8'h7F, 8'h7F},
    '{SEL_PORT_A_LATCH, 8'hFF, 8'h00, 8'h7F}};
  logic [7:0] wr_exp [9] = '{8'hFD, 8'hF7, 8'hFF, 8'hFF, 8'hDF, 8'hF7, 8'h1F, 8'h7F, 8'h7F};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_por_bor = 1'b0;
  logic i_other_rst = 1'b0;
  logic i_sleep = 1'b0;
  logic i_wake_wdt = 1'b0;
  logic i_wake_irq = 1'b0;
  logic i_wake_irq_high = 1'b0;
  logic [7:0] i_wake_irq_flags = 8'h00;
  logic i_high_prio_global_irq_enable = 1'b0;
  logic i_low_prio_global_irq_enable = 1'b0;
  logic [20:0] i_pc = 21'h000000;
  osc_mode_t i_osc_mode = OSC_EXT_CLK_IO;
  logic i_ra6_present = 1'b1;
  logic [7:0] i_port_a_pins = 8'h00;
  wr_req_t i_wr = '0;
  regs_t o_regs;
  logic o_asleep;
  logic o_pc_load;
  logic [20:0] o_pc_vector;
  stack_top_t o_stack_top;
  logic [4:0] o_return_stack_pointer;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [4:0] exp_sp = 5'h00;
  logic [7:0] exp_pflag = 8'h00;
  reset_state_initializer DUT (.i_clk(i_clk), .i_rst(i_rst), .i_por_bor(i_por_bor),
    .i_other_rst(i_other_rst), .i_sleep(i_sleep), .i_wake_wdt(i_wake_wdt),
    .i_wake_irq(i_wake_irq), .i_wake_irq_high(i_wake_irq_high),
    .i_wake_irq_flags(i_wake_irq_flags),
    .i_high_prio_global_irq_enable(i_high_prio_global_irq_enable),
    .i_low_prio_global_irq_enable(i_low_prio_global_irq_enable),
    .i_pc(i_pc), .i_osc_mode(i_osc_mode),
    .i_ra6_present(i_ra6_present), .i_port_a_pins(i_port_a_pins), .i_wr(i_wr),
    .o_regs(o_regs), .o_asleep(o_asleep), .o_pc_load(o_pc_load), .o_pc_vector(o_pc_vector),
    .o_stack_top(o_stack_top), .o_return_stack_pointer(o_return_stack_pointer));
  always #50 i_clk = ~i_clk;
  function automatic logic [7:0] fld(regs_t r, reg_sel_t s);
    case (s)
      SEL_CONV0: fld = r.conv0;
      SEL_TX: fld = r.tx;
      SEL_RX: fld = r.rx;
      SEL_TIMER3: fld = r.timer3;
      SEL_EEPROM1: fld = r.eeprom1;
      SEL_PORT_E_DIR: fld = r.port_e_dir;
      SEL_PRIO2: fld = r.prio2;
      SEL_PORT_A_DIR: fld = r.port_a_dir;
      default: fld = r.port_a_latch;
    endcase
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_rows(input int col, input string name);
    logic [7:0] e;
    for (int i = 0; i < 9; i++) begin
      e = (col == 0) ? rows[i].por : (col == 1) ? wr_exp[i] : rows[i].oth;
      `CHK(fld(o_regs, rows[i].sel), e)
    end
    $display("test %s done", name);
  endtask
  task automatic write_reg(input reg_sel_t s, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= '{1'b1, s, d};
    @(posedge i_clk);
    i_wr <= '0;
    #1;
  endtask
  task automatic do_wake(input logic irq, input logic high, input logic eh, input logic el,
                         input logic [20:0] pc, input logic [7:0] fl);
    logic vec;
    logic full;
    vec = irq && (high ? eh : el);
    full = (exp_sp == 5'h1F);
    @(posedge i_clk);
    i_sleep <= 1'b1;
    @(posedge i_clk);
    i_sleep <= 1'b0;
    i_wake_irq <= irq;
    i_wake_wdt <= !irq;
    i_wake_irq_high <= high;
    i_high_prio_global_irq_enable <= eh;
    i_low_prio_global_irq_enable <= el;
    i_pc <= pc;
    i_wake_irq_flags <= fl;
    #1 `CHK(o_asleep, 1'b1)
    @(posedge i_clk);
    i_wake_irq <= 1'b0;
    i_wake_wdt <= 1'b0;
    #1 `CHK(o_asleep, 1'b0)
    if (irq) begin
      exp_pflag = exp_pflag | fl;
      `CHK(o_regs.pflag, exp_pflag)
    end else begin
      `CHK(o_regs.ictl[2], 1'b1)
    end
    `CHK(o_pc_load, 1'b0)
    @(posedge i_clk);
    #1;
    if (vec) begin
      `CHK(o_pc_load, 1'b1)
      `CHK(o_pc_vector, high ? 21'h000008 : 21'h000018)
    end else begin
      `CHK(o_pc_load, 1'b0)
    end
    if (vec && !full) begin
      exp_sp = exp_sp + 5'h01;
      `CHK(o_stack_top, {3'h0, pc})
    end
    `CHK(o_return_stack_pointer, exp_sp)
    @(posedge i_clk);
    #1 `CHK(o_pc_load, 1'b0)
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 check_rows(0, "power_on");
    `CHK(o_return_stack_pointer, 5'h00)
    for (int i = 0; i < 9; i++) write_reg(rows[i].sel, rows[i].wr);
    check_rows(1, "writes");
    @(posedge i_clk);
    i_wake_irq <= 1'b1;
    i_high_prio_global_irq_enable <= 1'b1;
    i_wake_irq_high <= 1'b1;
    @(posedge i_clk);
    i_wake_irq <= 1'b0;
    repeat (3) begin
      @(posedge i_clk);
      #1 `CHK(o_pc_load, 1'b0)
    end
    $display("test wake_in_run done");
    do_wake(1'b0, 1'b0, 1'b1, 1'b1, 21'h000000, 8'h00);
    do_wake(1'b1, 1'b1, 1'b1, 1'b0, 21'h1A5C3E, 8'h01);
    do_wake(1'b1, 1'b0, 1'b0, 1'b1, 21'h0F0F01, 8'h10);
    do_wake(1'b1, 1'b1, 1'b0, 1'b1, 21'h123456, 8'h04);
    check_rows(1, "hold_across_wake");
    write_reg(SEL_ICTL, 8'h00);
    `CHK(o_regs.ictl, 8'h00)
    write_reg(SEL_PFLAG, 8'h00);
    `CHK(o_regs.pflag, 8'h00)
    exp_pflag = 8'h00;
    $display("test flag_clear done");
    @(posedge i_clk);
    i_other_rst <= 1'b1;
    @(posedge i_clk);
    i_other_rst <= 1'b0;
    #1 check_rows(2, "other_reset");
    exp_sp = 5'h00;
    exp_pflag = 8'h00;
    `CHK(o_return_stack_pointer, exp_sp)
    @(posedge i_clk);
    i_por_bor <= 1'b1;
    i_wr <= '{1'b1, SEL_TIMER3, 8'h5A};
    @(posedge i_clk);
    i_por_bor <= 1'b0;
    i_wr <= '0;
    #1 check_rows(0, "por_with_write");
    write_reg(SEL_PORT_A_LATCH, 8'hFF);
    for (int m = 0; m < 8; m++) begin
      @(posedge i_clk);
      i_osc_mode <= osc_mode_t'(m);
      i_port_a_pins <= 8'hFF;
      #1 `CHK(o_regs.port_a_dir, (m >= 6) ? 8'h7F : 8'h3F)
      `CHK(o_regs.port_a_latch, (m >= 6) ? 8'h7F : 8'h3F)
      `CHK(o_regs.port_a_pins, (m >= 6) ? 8'h7F : 8'h3F)
    end
    @(posedge i_clk);
    i_ra6_present <= 1'b0;
    #1 `CHK(o_regs.port_a_pins, 8'h3F)
    `CHK(o_regs.port_a_dir, 8'h3F)
    `CHK(o_regs.port_a_latch, 8'h3F)
    $display("test port_a_bit6 done");
    repeat (31) do_wake(1'b1, 1'b1, 1'b1, 1'b0, 21'h00ABCD, 8'h02);
    do_wake(1'b1, 1'b1, 1'b1, 1'b0, 21'h1FFFFF, 8'h02);
    `CHK(o_return_stack_pointer, 5'h1F)
    `CHK(o_stack_top, {3'h0, 21'h00ABCD})
    $display("test stack_saturate done");
    give_verdict();
  end
endmodule
